// File: flic_cpu_model.sv
module flic_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pacing from the bench
  input wire logic [2:0] instr_len,
  input wire logic return_from_interrupt_req,
  // Sequencer view
  output logic instr_last_cycle,
  output logic instr_is_return_from_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;
  logic return_from_interrupt_q;
  assign instr_last_cycle = (cnt_q + 3'h1 >= instr_len);
  assign instr_is_return_from_interrupt = return_from_interrupt_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 3'h0;
      return_from_interrupt_q <= 1'b0;
    end else if (instr_last_cycle) begin
      cnt_q <= 3'h0;
      // One return per request, a held request must not pop two levels
      return_from_interrupt_q <= return_from_interrupt_req && !return_from_interrupt_q;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule : flic_cpu_model

// File: flic_pkg.sv
package flic_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int N_SRC = 14;
  localparam int NFLAG = 28;
  localparam int N_REGS = 11;
  localparam int N_LVL = 4;

  // ----------------------------------------
  // Flag indices
  // ----------------------------------------
  localparam int F_IE0 = 0;
  localparam int F_TF0 = 1;
  localparam int F_IE1 = 2;
  localparam int F_TF1 = 3;
  localparam int F_RX = 4;
  localparam int F_TX = 5;
  localparam int F_TF2 = 6;
  localparam int F_TIMER2_EXTERNAL_FLAG = 7;
  localparam int F_IE2 = 8;
  localparam int F_SPI = 9;
  localparam int F_ADC = 10;
  localparam int F_CF = 11;
  localparam int F_CCF0 = 12;
  localparam int F_WDT = 18;
  localparam int F_BROWNOUT_ONE_FLAG = 19;
  localparam int F_BROWNOUT_ZERO_FLAG = 20;
  localparam int F_RTC = 21;
  localparam int F_MCD = 22;
  localparam int F_STA = 23;
  localparam int F_STO = 24;
  localparam int F_KB = 25;
  localparam int F_TWI = 26;
  localparam int F_AC0 = 27;
  // Flags driven from the pins, not from peripherals
  localparam logic [NFLAG-1:0] EXT_MASK = 28'h0000105;

  // ----------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------
  localparam logic [3:0] R_TIMER_CONTROL_REG = 4'h0;
  localparam logic [3:0] R_IE = 4'h1;
  localparam logic [3:0] R_EXT2_CONTROL_REG = 4'h2;
  localparam logic [3:0] R_EIE = 4'h3;
  localparam logic [3:0] R_PLO = 4'h4;
  localparam logic [3:0] R_PHI = 4'h5;
  localparam logic [3:0] R_POL = 4'h6;
  localparam logic [3:0] R_PERIPH = 4'h7;
  localparam logic [3:0] R_PCON = 4'h8;
  localparam logic [3:0] R_AUX = 4'h9;
  localparam logic [3:0] R_STAT = 4'ha;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TC_IT0 = 0;
  localparam int TC_IT1 = 2;
  localparam int IE_GATE = 7;
  localparam int XI_IT2 = 0;
  localparam int XI_EX2 = 2;
  localparam int XI_POL2 = 3;
  localparam int AUX_SHARE = 0;
  localparam logic [7:0] IE_WMASK = 8'hbf;
  localparam logic [7:0] EIE_WMASK = 8'hef;

  // ----------------------------------------
  // Vectors and answers
  // ----------------------------------------
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : flic_pkg

// File: flic_top.sv
module flic_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External request pins, active low by default
  input wire logic [2:0] ext_irq_pin,
  // Peripheral flag set pulses
  input wire logic [flic_pkg::NFLAG-1:0] periph_flag_set,
  // CPU sequencer
  input wire logic instr_last_cycle,
  input wire logic instr_is_return_from_interrupt,
  // Vectoring
  output logic long_call,
  output logic [15:0] vector_addr,
  output logic [3:0] vector_src,
  output logic [flic_pkg::NFLAG-1:0] irq_flags
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:6] == '0) && (a[5:2] < 4'(flic_pkg::N_REGS)) && (a[1:0] == 2'h0);
  endfunction : addr_ok

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [flic_pkg::NFLAG-1:0] flag_q, flag_d;
  logic it0_q, it1_q, it2_q, int2h_q, ex2_q, share_q;
  logic [7:0] ie_q, eie_q;
  logic [flic_pkg::N_SRC-1:0] plo_q, phi_q, req_q;
  logic [1:0] pol_q;
  logic [3:0] isr_q, isr_d;
  logic wrote_q;
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic call_q;
  logic [15:0] vaddr_q;
  logic [3:0] vsrc_q;

  // ----------------------------------------
  // Register view
  // ----------------------------------------
  logic [31:0] view [0:flic_pkg::N_REGS-1];
  logic [flic_pkg::NFLAG-1:0] f;
  assign f = flag_q;

  assign view[flic_pkg::R_TIMER_CONTROL_REG] = {24'h0, f[flic_pkg::F_TF1], 1'b0, f[flic_pkg::F_TF0], 1'b0,
                                   f[flic_pkg::F_IE1], it1_q, f[flic_pkg::F_IE0], it0_q};
  assign view[flic_pkg::R_IE] = {24'h0, ie_q};
  assign view[flic_pkg::R_EXT2_CONTROL_REG] = {28'h0, int2h_q, ex2_q, f[flic_pkg::F_IE2], it2_q};
  assign view[flic_pkg::R_EIE] = {24'h0, eie_q};
  assign view[flic_pkg::R_PLO] = {18'h0, plo_q};
  assign view[flic_pkg::R_PHI] = {18'h0, phi_q};
  assign view[flic_pkg::R_POL] = {30'h0, pol_q};
  assign view[flic_pkg::R_PERIPH] = {16'h0, f[flic_pkg::F_AC0], f[flic_pkg::F_TWI], f[flic_pkg::F_KB],
                                     f[flic_pkg::F_CCF0+5:flic_pkg::F_CCF0], f[flic_pkg::F_CF],
                                     f[flic_pkg::F_ADC], f[flic_pkg::F_SPI], f[flic_pkg::F_TIMER2_EXTERNAL_FLAG],
                                     f[flic_pkg::F_TF2], f[flic_pkg::F_TX], f[flic_pkg::F_RX]};
  assign view[flic_pkg::R_PCON] = {26'h0, f[flic_pkg::F_MCD], f[flic_pkg::F_RTC], 1'b0,
                                   f[flic_pkg::F_BROWNOUT_ZERO_FLAG], f[flic_pkg::F_BROWNOUT_ONE_FLAG], f[flic_pkg::F_WDT]};
  assign view[flic_pkg::R_AUX] = {24'h0, f[flic_pkg::F_STA], f[flic_pkg::F_STO], 5'h0, share_q};
  assign view[flic_pkg::R_STAT] = {14'h0, req_q, isr_q};

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic aw_hs, w_hs, w_fire, ar_hs, w_ok, r_ok;
  logic [3:0] widx;
  logic [31:0] wval, rval;
  logic wr_irq_now;

  assign aw_hs = s_axi_awvalid & aw_rdy_q;
  assign w_hs = s_axi_wvalid & w_rdy_q;
  // Address and data may arrive in either order
  assign w_fire = ~aw_rdy_q & ~w_rdy_q & ~bvalid_q;
  assign ar_hs = s_axi_arvalid & ar_rdy_q;
  assign widx = awaddr_q[5:2];
  assign w_ok = addr_ok(awaddr_q);
  assign r_ok = addr_ok(s_axi_araddr);
  assign wval = merge(w_ok ? view[widx] : 32'h0, wdata_q, wstrb_q);
  assign rval = r_ok ? view[s_axi_araddr[5:2]] : 32'h0;
  assign wr_irq_now = w_fire & w_ok & (widx == flic_pkg::R_IE || widx == flic_pkg::R_EXT2_CONTROL_REG ||
                      widx == flic_pkg::R_EIE || widx == flic_pkg::R_PLO || widx == flic_pkg::R_PHI);

  // Software flag writes
  logic [flic_pkg::NFLAG-1:0] sw_m, sw_v;
  always_comb begin
    sw_m = '0;
    sw_v = '0;
    if (w_fire && w_ok) begin
      case (widx)
        flic_pkg::R_TIMER_CONTROL_REG: begin
          sw_m[flic_pkg::F_IE0] = 1'b1;
          sw_m[flic_pkg::F_TF0] = 1'b1;
          sw_m[flic_pkg::F_IE1] = 1'b1;
          sw_m[flic_pkg::F_TF1] = 1'b1;
          sw_v[flic_pkg::F_IE0] = wval[1];
          sw_v[flic_pkg::F_TF0] = wval[5];
          sw_v[flic_pkg::F_IE1] = wval[3];
          sw_v[flic_pkg::F_TF1] = wval[7];
        end
        flic_pkg::R_EXT2_CONTROL_REG: begin
          sw_m[flic_pkg::F_IE2] = 1'b1;
          sw_v[flic_pkg::F_IE2] = wval[1];
        end
        flic_pkg::R_PERIPH: begin
          sw_m[flic_pkg::F_RX] = 1'b1;
          sw_m[flic_pkg::F_TX] = 1'b1;
          sw_m[flic_pkg::F_TF2] = 1'b1;
          sw_m[flic_pkg::F_TIMER2_EXTERNAL_FLAG] = 1'b1;
          sw_m[flic_pkg::F_SPI] = 1'b1;
          sw_m[flic_pkg::F_ADC] = 1'b1;
          sw_m[flic_pkg::F_CCF0+5:flic_pkg::F_CF] = 7'h7f;
          sw_m[flic_pkg::F_KB] = 1'b1;
          sw_m[flic_pkg::F_TWI] = 1'b1;
          sw_m[flic_pkg::F_AC0] = 1'b1;
          sw_v[flic_pkg::F_RX] = wval[0];
          sw_v[flic_pkg::F_TX] = wval[1];
          sw_v[flic_pkg::F_TF2] = wval[2];
          sw_v[flic_pkg::F_TIMER2_EXTERNAL_FLAG] = wval[3];
          sw_v[flic_pkg::F_SPI] = wval[4];
          sw_v[flic_pkg::F_ADC] = wval[5];
          sw_v[flic_pkg::F_CCF0+5:flic_pkg::F_CF] = wval[12:6];
          sw_v[flic_pkg::F_KB] = wval[13];
          sw_v[flic_pkg::F_TWI] = wval[14];
          sw_v[flic_pkg::F_AC0] = wval[15];
        end
        flic_pkg::R_PCON: begin
          sw_m[flic_pkg::F_MCD:flic_pkg::F_WDT] = 5'h1f;
          sw_v[flic_pkg::F_WDT] = wval[0];
          sw_v[flic_pkg::F_BROWNOUT_ONE_FLAG] = wval[1];
          sw_v[flic_pkg::F_BROWNOUT_ZERO_FLAG] = wval[2];
          sw_v[flic_pkg::F_RTC] = wval[4];
          sw_v[flic_pkg::F_MCD] = wval[5];
        end
        flic_pkg::R_AUX: begin
          sw_m[flic_pkg::F_STO:flic_pkg::F_STA] = 2'h3;
          sw_v[flic_pkg::F_STA] = wval[7];
          sw_v[flic_pkg::F_STO] = wval[6];
        end
        default: begin
          sw_m = '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // External inputs
  // ----------------------------------------
  logic [2:0] hi_act, trig_edge, act_now, act_prev, ext_edge;
  assign hi_act = {int2h_q, pol_q};
  assign trig_edge = {it2_q, it1_q, it0_q};
  assign act_now = ~(pin_s2_q ^ hi_act);
  assign act_prev = ~(pin_s3_q ^ hi_act);
  assign ext_edge = act_now & ~act_prev;

  // ----------------------------------------
  // Requests and arbitration
  // ----------------------------------------
  logic [flic_pkg::N_SRC-1:0] raw, en, req;
  logic sys_req;
  assign sys_req = |f[flic_pkg::F_STO:flic_pkg::F_WDT] | (f[flic_pkg::F_TX] & share_q);
  assign raw = {f[flic_pkg::F_AC0], f[flic_pkg::F_TWI], f[flic_pkg::F_KB], sys_req,
                |f[flic_pkg::F_CCF0+5:flic_pkg::F_CF],
                f[flic_pkg::F_ADC], f[flic_pkg::F_SPI], f[flic_pkg::F_IE2],
                f[flic_pkg::F_TF2] | f[flic_pkg::F_TIMER2_EXTERNAL_FLAG],
                f[flic_pkg::F_RX] | f[flic_pkg::F_TX],
                f[flic_pkg::F_TF1], f[flic_pkg::F_IE1], f[flic_pkg::F_TF0], f[flic_pkg::F_IE0]};
  assign en = {eie_q[7:5], eie_q[3:0], ex2_q, ie_q[5:0]};
  assign req = raw & en & {flic_pkg::N_SRC{ie_q[flic_pkg::IE_GATE]}};

  logic found;
  logic [3:0] best_id;
  logic [1:0] best_lvl;
  always_comb begin
    found = 1'b0;
    best_id = 4'h0;
    best_lvl = 2'h0;
    // Walk downward so that equal levels leave the lowest number
    for (int i = flic_pkg::N_SRC - 1; i >= 0; i--) begin
      if (req_q[i] && (!found || {phi_q[i], plo_q[i]} >= best_lvl)) begin
        found = 1'b1;
        best_id = 4'(i);
        best_lvl = {phi_q[i], plo_q[i]};
      end
    end
  end

  logic prio_block, take, return_from_interrupt_done;
  assign prio_block = |(isr_q >> best_lvl);
  assign take = found & instr_last_cycle & ~prio_block
                & ~instr_is_return_from_interrupt & ~wrote_q & ~wr_irq_now;
  assign return_from_interrupt_done = instr_last_cycle & instr_is_return_from_interrupt;

  always_comb begin
    isr_d = isr_q;
    if (return_from_interrupt_done) begin
      // Only the innermost routine returns
      for (int l = 0; l < flic_pkg::N_LVL; l++) begin
        if (isr_q[l] && (isr_q >> (l + 1)) == 4'h0) begin
          isr_d[l] = 1'b0;
        end
      end
    end
    if (take) begin
      isr_d[best_lvl] = 1'b1;
    end
  end

  // ----------------------------------------
  // Flag update
  // ----------------------------------------
  logic [flic_pkg::NFLAG-1:0] vec_clr, hw_set;
  always_comb begin
    vec_clr = '0;
    if (take) begin
      case (best_id)
        4'h0: vec_clr[flic_pkg::F_IE0] = it0_q;
        4'h1: vec_clr[flic_pkg::F_TF0] = 1'b1;
        4'h2: vec_clr[flic_pkg::F_IE1] = it1_q;
        4'h3: vec_clr[flic_pkg::F_TF1] = 1'b1;
        4'h6: vec_clr[flic_pkg::F_IE2] = it2_q;
        default: vec_clr = '0;
      endcase
    end
  end

  always_comb begin
    hw_set = periph_flag_set & ~flic_pkg::EXT_MASK;
    hw_set[flic_pkg::F_IE0] = trig_edge[0] & ext_edge[0];
    hw_set[flic_pkg::F_IE1] = trig_edge[1] & ext_edge[1];
    hw_set[flic_pkg::F_IE2] = trig_edge[2] & ext_edge[2];
    // A hardware set in the same cycle as a clear wins
    flag_d = (((flag_q & ~sw_m) | (sw_v & sw_m)) & ~vec_clr) | hw_set;
    // Level mode follows the pin
    if (!trig_edge[0]) flag_d[flic_pkg::F_IE0] = act_now[0];
    if (!trig_edge[1]) flag_d[flic_pkg::F_IE1] = act_now[1];
    if (!trig_edge[2]) flag_d[flic_pkg::F_IE2] = act_now[2];
  end

  // ----------------------------------------
  // Sequential
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
      pin_s3_q <= 3'h7;
      flag_q <= '0;
      req_q <= '0;
      isr_q <= 4'h0;
      wrote_q <= 1'b0;
      call_q <= 1'b0;
      vaddr_q <= 16'h0;
      vsrc_q <= 4'h0;
    end else begin
      pin_s1_q <= ext_irq_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      flag_q <= flag_d;
      req_q <= req;
      isr_q <= isr_d;
      wrote_q <= instr_last_cycle ? 1'b0 : (wrote_q | wr_irq_now);
      call_q <= take;
      if (take) begin
        vaddr_q <= flic_pkg::VEC_BASE + {9'h0, best_id, 3'h0};
        vsrc_q <= best_id;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      {it0_q, it1_q, it2_q, int2h_q, ex2_q, share_q} <= 6'h0;
      ie_q <= 8'h0;
      eie_q <= 8'h0;
      plo_q <= '0;
      phi_q <= '0;
      pol_q <= 2'h0;
    end else if (w_fire && w_ok) begin
      case (widx)
        flic_pkg::R_TIMER_CONTROL_REG: begin
          it0_q <= wval[flic_pkg::TC_IT0];
          it1_q <= wval[flic_pkg::TC_IT1];
        end
        flic_pkg::R_IE: ie_q <= wval[7:0] & flic_pkg::IE_WMASK;
        flic_pkg::R_EXT2_CONTROL_REG: begin
          it2_q <= wval[flic_pkg::XI_IT2];
          ex2_q <= wval[flic_pkg::XI_EX2];
          int2h_q <= wval[flic_pkg::XI_POL2];
        end
        flic_pkg::R_EIE: eie_q <= wval[7:0] & flic_pkg::EIE_WMASK;
        flic_pkg::R_PLO: plo_q <= wval[flic_pkg::N_SRC-1:0];
        flic_pkg::R_PHI: phi_q <= wval[flic_pkg::N_SRC-1:0];
        flic_pkg::R_POL: pol_q <= wval[1:0];
        flic_pkg::R_AUX: share_q <= wval[flic_pkg::AUX_SHARE];
        default: share_q <= share_q;
      endcase
    end
  end

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= flic_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_rdy_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_rdy_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (w_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= w_ok ? flic_pkg::RESP_OKAY : flic_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ar_rdy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= flic_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rval;
      rresp_q <= r_ok ? flic_pkg::RESP_OKAY : flic_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      ar_rdy_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = w_rdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign long_call = call_q;
  assign vector_addr = vaddr_q;
  assign vector_src = vsrc_q;
  assign irq_flags = flag_q;

endmodule : flic_top

// File: flic_top_monitor.sv
module flic_top_monitor #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus answers
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rready,
  // Interrupt path
  input wire logic [flic_pkg::NFLAG-1:0] periph_flag_set,
  input wire logic instr_last_cycle,
  input wire logic instr_is_return_from_interrupt,
  input wire logic long_call,
  input wire logic [15:0] vector_addr,
  input wire logic [3:0] vector_src,
  input wire logic [flic_pkg::NFLAG-1:0] irq_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_bwait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence s_rwait; s_axi_rvalid && !s_axi_rready; endsequence
  // Hardware set wins over the vectoring clear, so skip that case
  sequence s_t0_call; long_call && vector_src == 4'h1 && !$past(periph_flag_set[flic_pkg::F_TF0]); endsequence
  poll_last_a: assert property (long_call |-> $past(instr_last_cycle))
    else $error("call outside last instruction cycle");
  no_return_from_interrupt_a: assert property (long_call |-> !$past(instr_is_return_from_interrupt))
    else $error("call during return instruction");
  vector_map_a: assert property (long_call |-> vector_addr == flic_pkg::VEC_BASE + {9'h0, vector_src, 3'h0})
    else $error("vector address not base plus eight per source");
  source_range_a: assert property (long_call |-> vector_src <= 4'hd)
    else $error("call for nonexistent source");
  vector_hold_a: assert property (!long_call |-> $stable(vector_addr) && $stable(vector_src))
    else $error("vector changed without a call");
  timer_clear_a: assert property (s_t0_call |-> !irq_flags[flic_pkg::F_TF0])
    else $error("timer flag left set after vectoring");
  serial_sticky_a: assert property (long_call && vector_src == 4'h4 |-> irq_flags[flic_pkg::F_RX] || irq_flags[flic_pkg::F_TX])
    else $error("serial flags cleared on vectoring");
  pca_sticky_a: assert property (long_call && vector_src == 4'h9 |-> |irq_flags[flic_pkg::F_CCF0+5:flic_pkg::F_CF])
    else $error("counter array flags cleared on vectoring");
  bresp_hold_a: assert property (s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  rdata_hold_a: assert property (s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
endmodule : flic_top_monitor

bind flic_top flic_top_monitor #(.ADDR_W(ADDR_W)) u_monitor (.clk(clk), .reset(reset),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rready(s_axi_rready),
  .periph_flag_set(periph_flag_set), .instr_last_cycle(instr_last_cycle), .instr_is_return_from_interrupt(instr_is_return_from_interrupt),
  .long_call(long_call), .vector_addr(vector_addr), .vector_src(vector_src), .irq_flags(irq_flags));

// File: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [27:0] pset = 28'h0;
  logic [2:0] ilen = 3'h1;
  logic [2:0] pins = 3'h7;
  logic return_from_interrupt_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, long_call, last, is_return_from_interrupt;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] vaddr, call_addr;
  logic [3:0] vsrc, call_src;
  logic [27:0] flags;
  int fails = 0, n_checks = 0, n_calls = 0, seen = 0;
  logic [3:0] f_reg [14] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h7, 4'h7, 4'h2, 4'h7, 4'h7, 4'h7, 4'h8, 4'h7, 4'h7, 4'h7};
  logic [31:0] f_val [14] = '{32'h3, 32'h20, 32'hc, 32'h80, 32'h1, 32'h4, 32'h7, 32'h10, 32'h20, 32'h80, 32'h1,
    32'h2000, 32'h4000, 32'h8000};
  // Edge-mode externals and timers 0/1 lose their flag on vectoring
  logic [31:0] f_keep [14] = '{32'h1, 32'h0, 32'h4, 32'h0, 32'h1, 32'h4, 32'h5, 32'h10, 32'h20, 32'h80, 32'h1,
    32'h2000, 32'h4000, 32'h8000};
  always #4 clk = ~clk;
  flic_top dut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_irq_pin(pins), .periph_flag_set(pset), .instr_last_cycle(last), .instr_is_return_from_interrupt(is_return_from_interrupt),
    .long_call(long_call), .vector_addr(vaddr), .vector_src(vsrc), .irq_flags(flags));
  flic_cpu_model cpu (.clk(clk), .reset(reset), .instr_len(ilen), .return_from_interrupt_req(return_from_interrupt_req),
    .instr_last_cycle(last), .instr_is_return_from_interrupt(is_return_from_interrupt));
  // Calls last one cycle, so catch them here rather than in the waits
  always @(posedge clk) begin
    if (long_call === 1'b1) begin
      n_calls <= n_calls + 1;
      call_src <= vsrc;
      call_addr <= vaddr;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic give_up;
    fails++;
    $display("ERROR %0t: wait ran out", $time);
    stop_test();
  endtask : give_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] idx, input logic [31:0] d, input logic [1:0] er = flic_pkg::RESP_OKAY);
    int n;
    n = 0;
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready) && n < 40);
    if (!(bvalid && bready)) give_up();
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input logic [1:0] er = flic_pkg::RESP_OKAY);
    int n;
    n = 0;
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 40);
    if (!(rvalid && rready)) give_up();
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd
  task automatic wait_call(input logic [3:0] src, input int lat);
    int n;
    n = 0;
    while (n_calls == seen && n < 80) begin
      @(posedge clk);
      n++;
      pset <= '0;
    end
    if (n_calls == seen) give_up();
    seen++;
    chk({28'h0, call_src}, {28'h0, src});
    chk({16'h0, call_addr}, 32'h3 + {25'h0, src, 3'h0});
    if (lat > 0) chk(n, lat);
  endtask : wait_call
  task automatic no_call(input int cycles);
    int c0;
    c0 = n_calls;
    repeat (cycles) begin
      @(posedge clk);
      pset <= '0;
    end
    chk(n_calls, c0);
  endtask : no_call
  task automatic return_from_interrupt;
    int n;
    n = 0;
    return_from_interrupt_req <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!(is_return_from_interrupt && last) && n < 20);
    if (n >= 20) give_up();
    return_from_interrupt_req <= 1'b0;
  endtask : return_from_interrupt
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 11; i++) rd(i[3:0], 32'h0);
    rd(4'hb, 32'h0, flic_pkg::RESP_SLVERR);
    wr(4'hb, 32'hffffffff, flic_pkg::RESP_SLVERR);
    wr(flic_pkg::R_IE, 32'hff);
    rd(flic_pkg::R_IE, 32'hbf);
    wr(flic_pkg::R_EIE, 32'hff);
    rd(flic_pkg::R_EIE, 32'hef);
    wr(flic_pkg::R_EIE, 32'h0);
    wr(flic_pkg::R_IE, 32'h10);
    wr(flic_pkg::R_PERIPH, 32'h1);
    no_call(20);
    wr(flic_pkg::R_IE, 32'h90);
    wait_call(4'h4, 0);
    wr(flic_pkg::R_PERIPH, 32'h0);
    return_from_interrupt();
    ilen <= 3'h3;
    for (int s = 0; s < 14; s++) begin
      wr(flic_pkg::R_IE, 32'h80 | (s < 6 ? 32'h1 << s : 32'h0));
      wr(flic_pkg::R_EIE, s > 10 ? 32'h1 << (s - 6) : (s > 6 ? 32'h1 << (s - 7) : 32'h0));
      // Type bit first: a flag written with it still obeys the old mode
      if (f_val[s] != f_keep[s]) wr(f_reg[s], f_keep[s]);
      wr(f_reg[s], f_val[s]);
      wait_call(s[3:0], 0);
      rd(f_reg[s], f_keep[s]);
      wr(f_reg[s], 32'h0);
      return_from_interrupt();
    end
    ilen <= 3'h1;
    wr(flic_pkg::R_PHI, 32'h2000);
    wr(flic_pkg::R_PLO, 32'h2000);
    wr(flic_pkg::R_IE, 32'h82);
    wr(flic_pkg::R_EIE, 32'h81);
    pset <= 28'h1 << flic_pkg::F_TF0 | 28'h1 << flic_pkg::F_AC0;
    wait_call(4'hd, 5);
    wr(flic_pkg::R_PERIPH, 32'h0);
    no_call(10);
    return_from_interrupt();
    wait_call(4'h1, 0);
    pset <= 28'h1 << flic_pkg::F_TF0 | 28'h1 << flic_pkg::F_SPI;
    no_call(10);
    return_from_interrupt();
    wait_call(4'h1, 0);
    return_from_interrupt();
    wait_call(4'h7, 0);
    wr(flic_pkg::R_PERIPH, 32'h0);
    return_from_interrupt();
    wr(flic_pkg::R_AUX, 32'h1);
    wr(flic_pkg::R_IE, 32'h80);
    wr(flic_pkg::R_EIE, 32'h8);
    wr(flic_pkg::R_PERIPH, 32'h2);
    wait_call(4'ha, 0);
    wr(flic_pkg::R_PERIPH, 32'h0);
    return_from_interrupt();
    wr(flic_pkg::R_IE, 32'h81);
    pins <= 3'h6;
    wait_call(4'h0, 0);
    rd(flic_pkg::R_TIMER_CONTROL_REG, 32'h2);
    pins <= 3'h7;
    wr(flic_pkg::R_POL, 32'h1);
    rd(flic_pkg::R_TIMER_CONTROL_REG, 32'h2);
    stop_test();
  end
endmodule : tb
